/* File: pkg/oac_defs.vh */
// Constants for the operand address and operation class decoder
`ifndef OAC_DEFS_VH
`define OAC_DEFS_VH
// ----------------------------------------------------------------
// Address field layout
// ----------------------------------------------------------------
`define OAC_MOD_HI 7
`define OAC_MOD_LO 6
`define OAC_REG_HI 5
`define OAC_REG_LO 3
`define OAC_RM_HI 2
`define OAC_RM_LO 0
`define OAC_MOD_MEM0 2'h0
`define OAC_MOD_MEM8 2'h1
`define OAC_MOD_MEM16 2'h2
`define OAC_MOD_REG 2'h3
`define OAC_RM_DIRECT 3'h6
`define OAC_SEG_SHIFT 4
`define OAC_MODE_COUNT 5'h18
// Register indices
`define OAC_R_AX 3'h0
`define OAC_R_CX 3'h1
`define OAC_R_DX 3'h2
`define OAC_R_BX 3'h3
`define OAC_R_SP 3'h4
`define OAC_R_BP 3'h5
`define OAC_R_SI 3'h6
`define OAC_R_DI 3'h7
// Segment selectors
`define OAC_SEG_ES 2'h0
`define OAC_SEG_CS 2'h1
`define OAC_SEG_SS 2'h2
`define OAC_SEG_DS 2'h3
// ----------------------------------------------------------------
// Operation codes of the execute port
// ----------------------------------------------------------------
`define OAC_OP_MOVE 5'h00
`define OAC_OP_AND 5'h01
`define OAC_OP_OR 5'h02
`define OAC_OP_XOR 5'h03
`define OAC_OP_TEST 5'h04
`define OAC_OP_ADD 5'h05
`define OAC_OP_ADC 5'h06
`define OAC_OP_SUB 5'h07
`define OAC_OP_SBB 5'h08
`define OAC_OP_CMP 5'h09
`define OAC_OP_NOT 5'h0A
`define OAC_OP_SHL 5'h0B
`define OAC_OP_SHR 5'h0C
`define OAC_OP_SAR 5'h0D
`define OAC_OP_ROL 5'h0E
`define OAC_OP_ROR 5'h0F
`define OAC_OP_PUSH 5'h10
`define OAC_OP_POP 5'h11
`define OAC_OP_IN 5'h12
`define OAC_OP_OUT 5'h13
`define OAC_OP_FL2AH 5'h14
`define OAC_OP_AH2FL 5'h15
`define OAC_OP_FLAGS_PUSH_OP 5'h16
`define OAC_OP_FLAGS_POP_OP 5'h17
`define OAC_OP_JREL 5'h18
`define OAC_OP_DAA 5'h19
`define OAC_OP_AAA 5'h1A
// Flag bit positions
`define OAC_F_CF 0
`define OAC_F_AF 4
`define OAC_F_ZF 6
`define OAC_F_SF 7
`define OAC_F_OF 11
`define OAC_FLAGS_RST 16'h0002
`define OAC_FLAGS_MASK 16'h0FD5
`define OAC_SP_RST 16'h0000
`define OAC_WORD_STEP 16'h0002
`define OAC_LOW_NIB 4'h9
`define OAC_DEC_ADJ 8'h06
`define OAC_DEC_ADJ_HI 8'h60
`endif

/* File: design/oac_ea_unit.v */
// Effective and physical address former
`timescale 1ns/1ps
`default_nettype none
`include "oac_defs.vh"
module oac_ea_unit (
    input wire [7:0] i_modrm,
    input wire [15:0] i_disp,
    input wire [15:0] i_bx,
    input wire [15:0] i_bp,
    input wire [15:0] i_si,
    input wire [15:0] i_di,
    input wire [15:0] i_seg,
    output reg [15:0] o_ea,
    output reg o_is_reg,
    output reg o_bp_based,
    output wire [19:0] o_phys
);
    wire [1:0] mode = i_modrm[`OAC_MOD_HI:`OAC_MOD_LO];
    wire [2:0] rm = i_modrm[`OAC_RM_HI:`OAC_RM_LO];
    reg [15:0] base;
    reg [15:0] disp;
    always @* begin
        o_is_reg = (mode == `OAC_MOD_REG);
        o_bp_based = 1'b0;
        case (mode)
            `OAC_MOD_MEM8: disp = {{8{i_disp[7]}}, i_disp[7:0]};
            `OAC_MOD_MEM16: disp = i_disp;
            default: disp = 16'h0000;
        endcase
        case (rm)
            3'h0: base = i_bx + i_si;
            3'h1: base = i_bx + i_di;
            3'h2: begin
                base = i_bp + i_si;
                o_bp_based = 1'b1;
            end
            3'h3: begin
                base = i_bp + i_di;
                o_bp_based = 1'b1;
            end
            3'h4: base = i_si;
            3'h5: base = i_di;
            3'h6: begin
                base = i_bp;
                o_bp_based = 1'b1;
            end
            default: base = i_bx;
        endcase
        // Direct form replaces the bp-only form when no displacement
        if ((mode == `OAC_MOD_MEM0) && (rm == `OAC_RM_DIRECT)) begin
            base = 16'h0000;
            disp = i_disp;
            o_bp_based = 1'b0;
        end
        // Eight rm x three memory mods gives twenty-four forms
        o_ea = base + disp;
    end
    assign o_phys = {i_seg, 4'h0} + {4'h0, o_ea};
endmodule // oac_ea_unit
`default_nettype wire

/* File: design/oac_decoder.v */
// Operand addressing and operation class execution core
`timescale 1ns/1ps
`default_nettype none
`include "oac_defs.vh"
module oac_decoder (
    input wire i_ref_clk,
    input wire i_srst,
    input wire i_start,
    input wire [4:0] i_op,
    input wire i_word,
    input wire [7:0] i_modrm,
    input wire i_imm_src,
    input wire i_dir_to_mem,
    input wire [15:0] i_disp,
    input wire [15:0] i_imm,
    input wire [1:0] i_seg_ovr,
    input wire i_seg_ovr_en,
    input wire [7:0] i_shift_cnt,
    input wire i_shift_by_cl,
    input wire [15:0] i_port,
    input wire [15:0] i_ip,
    input wire [15:0] i_cs,
    input wire [15:0] i_ss,
    input wire [15:0] i_ds,
    input wire [15:0] i_es,
    input wire i_mem_ack,
    input wire [15:0] i_mem_rdata,
    output reg o_mem_req,
    output reg o_mem_we,
    output reg o_mem_io,
    output reg o_mem_word,
    output reg [19:0] o_mem_addr,
    output reg [15:0] o_mem_wdata,
    output wire o_busy,
    output reg o_done,
    output reg o_branch,
    output reg [15:0] o_next_ip,
    output reg [19:0] o_fetch_addr,
    output reg [15:0] o_flags,
    output reg [15:0] o_accumulator_word,
    output reg [15:0] o_stack_pointer_reg
);
    // ------------------------------------------------------------
    // State encoding
    // ------------------------------------------------------------
    localparam ST_IDLE = 5'h01;
    localparam ST_READ = 5'h02;
    localparam ST_EXEC = 5'h04;
    localparam ST_WRITE = 5'h08;
    localparam ST_DONE = 5'h10;
    reg [4:0] state;
    reg [15:0] gpr [0:7];
    reg [4:0] op;
    reg word;
    reg [7:0] modrm;
    reg imm_src;
    reg to_mem;
    reg [15:0] disp;
    reg [15:0] imm;
    reg [1:0] seg_ovr;
    reg seg_ovr_en;
    reg [7:0] cnt;
    reg [15:0] port;
    reg [15:0] opnd_mem;
    reg [15:0] flags;
    reg [15:0] result;
    reg wr_dst;
    // ------------------------------------------------------------
    // Address formation
    // ------------------------------------------------------------
    wire [15:0] ea;
    wire ea_is_reg;
    wire ea_bp;
    wire [19:0] phys;
    reg [15:0] seg_val;
    reg [1:0] seg_sel;
    always @* begin
        seg_sel = ea_bp ? `OAC_SEG_SS : `OAC_SEG_DS;
        if (seg_ovr_en) begin
            seg_sel = seg_ovr;
        end
        case (seg_sel)
            `OAC_SEG_ES: seg_val = i_es;
            `OAC_SEG_CS: seg_val = i_cs;
            `OAC_SEG_SS: seg_val = i_ss;
            default: seg_val = i_ds;
        endcase
    end
    oac_ea_unit u_ea (
        .i_modrm(modrm),
        .i_disp(disp),
        .i_bx(gpr[`OAC_R_BX]),
        .i_bp(gpr[`OAC_R_BP]),
        .i_si(gpr[`OAC_R_SI]),
        .i_di(gpr[`OAC_R_DI]),
        .i_seg(seg_val),
        .o_ea(ea),
        .o_is_reg(ea_is_reg),
        .o_bp_based(ea_bp),
        .o_phys(phys)
    );
    // Stack addresses always from stack segment
    wire [15:0] sp = gpr[`OAC_R_SP];
    wire [15:0] sp_dec = sp - `OAC_WORD_STEP;
    wire [19:0] stk_push_addr = {i_ss, 4'h0} + {4'h0, sp_dec};
    wire [19:0] stk_pop_addr = {i_ss, 4'h0} + {4'h0, sp};
    // ------------------------------------------------------------
    // Operand selection
    // ------------------------------------------------------------
    wire [2:0] reg_f = modrm[`OAC_REG_HI:`OAC_REG_LO];
    wire [2:0] rm_f = modrm[`OAC_RM_HI:`OAC_RM_LO];
    // Byte registers: 0-3 low halves, 4-7 high halves of 0-3
    function [15:0] rd_reg;
        input [2:0] idx;
        input w;
        begin
            if (w) begin
                rd_reg = gpr[idx];
            end else if (idx[2]) begin
                rd_reg = {8'h00, gpr[{1'b0, idx[1:0]}][15:8]};
            end else begin
                rd_reg = {8'h00, gpr[idx][7:0]};
            end
        end
    endfunction
    wire [15:0] rm_val = ea_is_reg ? rd_reg(rm_f, word) : opnd_mem;
    wire [15:0] reg_val = rd_reg(reg_f, word);
    wire [15:0] src = imm_src ? imm : (to_mem ? reg_val : rm_val);
    wire [15:0] dst = to_mem ? rm_val : reg_val;
    wire dst_is_mem = (to_mem || imm_src) && !ea_is_reg;
    wire needs_rm = (op != `OAC_OP_MOVE) || !to_mem;
    // ------------------------------------------------------------
    // Arithmetic and logic
    // ------------------------------------------------------------
    wire [16:0] sum = {1'b0, dst} + {1'b0, src} + {16'h0000, (op == `OAC_OP_ADC) & flags[`OAC_F_CF]};
    wire [16:0] dif = {1'b0, dst} - {1'b0, src} - {16'h0000, (op == `OAC_OP_SBB) & flags[`OAC_F_CF]};
    wire [7:0] al = gpr[`OAC_R_AX][7:0];
    reg [16:0] raw;
    reg [15:0] sh;
    reg sh_cf;
    integer k;
    always @* begin
        raw = {1'b0, dst};
        sh = dst;
        sh_cf = flags[`OAC_F_CF];
        // Serial loop bounded at 255 keeps rotate semantics exact
        for (k = 0; k < 255; k = k + 1) begin
            if (k < cnt) begin
                case (op)
                    `OAC_OP_SHL: begin
                        sh_cf = word ? sh[15] : sh[7];
                        sh = {sh[14:0], 1'b0};
                    end
                    `OAC_OP_SHR: begin
                        sh_cf = sh[0];
                        sh = {1'b0, sh[15:1]};
                    end
                    `OAC_OP_SAR: begin
                        sh_cf = sh[0];
                        sh = word ? {sh[15], sh[15:1]} : {8'h00, sh[7], sh[7:1]};
                    end
                    `OAC_OP_ROL: begin
                        sh_cf = word ? sh[15] : sh[7];
                        sh = word ? {sh[14:0], sh[15]} : {8'h00, sh[6:0], sh[7]};
                    end
                    `OAC_OP_ROR: begin
                        sh_cf = sh[0];
                        sh = word ? {sh[0], sh[15:1]} : {8'h00, sh[0], sh[7:1]};
                    end
                    default: sh = sh;
                endcase
            end
        end
        case (op)
            `OAC_OP_MOVE: raw = {1'b0, src};
            `OAC_OP_AND, `OAC_OP_TEST: raw = {1'b0, dst & src};
            `OAC_OP_OR: raw = {1'b0, dst | src};
            `OAC_OP_XOR: raw = {1'b0, dst ^ src};
            `OAC_OP_NOT: raw = {1'b0, ~dst};
            `OAC_OP_ADD, `OAC_OP_ADC: raw = word ? sum : {8'h00, sum[8:0]};
            `OAC_OP_SUB, `OAC_OP_SBB, `OAC_OP_CMP: raw = word ? dif : {8'h00, dif[8:0]};
            `OAC_OP_SHL, `OAC_OP_SHR, `OAC_OP_SAR, `OAC_OP_ROL, `OAC_OP_ROR: raw = {sh_cf, sh};
            `OAC_OP_DAA: begin
                // Packed: two digits per byte
                raw = {1'b0, 8'h00, al};
                if ((al[3:0] > `OAC_LOW_NIB) || flags[`OAC_F_AF]) begin
                    raw = raw + {9'h000, `OAC_DEC_ADJ};
                end
                if ((al > 8'h99) || flags[`OAC_F_CF]) begin
                    raw = raw + {9'h000, `OAC_DEC_ADJ_HI};
                    raw[16] = 1'b1;
                end
            end
            `OAC_OP_AAA: begin
                // Unpacked: one digit per byte, high nibble cleared
                raw = {1'b0, gpr[`OAC_R_AX]};
                if ((al[3:0] > `OAC_LOW_NIB) || flags[`OAC_F_AF]) begin
                    raw = {1'b1, gpr[`OAC_R_AX] + 16'h0106};
                end
                raw[7:4] = 4'h0;
            end
            default: raw = {1'b0, dst};
        endcase
    end
    wire res_zero = word ? (raw[15:0] == 16'h0000) : (raw[7:0] == 8'h00);
    wire res_sign = word ? raw[15] : raw[7];
    wire res_cy = word ? raw[16] : raw[8];
    wire logic_op = (op == `OAC_OP_AND) || (op == `OAC_OP_OR) || (op == `OAC_OP_XOR) || (op == `OAC_OP_TEST);
    wire sets_flags = logic_op || ((op >= `OAC_OP_ADD) && (op <= `OAC_OP_CMP)) ||
        ((op >= `OAC_OP_SHL) && (op <= `OAC_OP_ROR)) || (op == `OAC_OP_DAA) || (op == `OAC_OP_AAA);
    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    assign o_busy = (state != ST_IDLE);
    integer r;
    always @(posedge i_ref_clk) begin
        if (i_srst) begin
            state <= ST_IDLE;
            for (r = 0; r < 8; r = r + 1) begin
                gpr[r] <= `OAC_SP_RST;
            end
            op <= `OAC_OP_MOVE;
            word <= 1'b0;
            modrm <= 8'h00;
            imm_src <= 1'b0;
            to_mem <= 1'b0;
            disp <= 16'h0000;
            imm <= 16'h0000;
            seg_ovr <= `OAC_SEG_DS;
            seg_ovr_en <= 1'b0;
            cnt <= 8'h00;
            port <= 16'h0000;
            opnd_mem <= 16'h0000;
            flags <= `OAC_FLAGS_RST;
            result <= 16'h0000;
            wr_dst <= 1'b0;
            o_mem_req <= 1'b0;
            o_mem_we <= 1'b0;
            o_mem_io <= 1'b0;
            o_mem_word <= 1'b0;
            o_mem_addr <= 20'h00000;
            o_mem_wdata <= 16'h0000;
            o_done <= 1'b0;
            o_branch <= 1'b0;
            o_next_ip <= 16'h0000;
            o_fetch_addr <= 20'h00000;
        end else begin
            o_done <= 1'b0;
            o_branch <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (i_start) begin
                        op <= i_op;
                        word <= i_word;
                        modrm <= i_modrm;
                        imm_src <= i_imm_src;
                        to_mem <= i_dir_to_mem;
                        disp <= i_disp;
                        imm <= i_imm;
                        seg_ovr <= i_seg_ovr;
                        seg_ovr_en <= i_seg_ovr_en;
                        cnt <= i_shift_by_cl ? gpr[`OAC_R_CX][7:0] : i_shift_cnt;
                        port <= i_port;
                        state <= ST_READ;
                    end
                end
                ST_READ: begin
                    // Issue the single read that an operation needs
                    case (op)
                        `OAC_OP_POP, `OAC_OP_FLAGS_POP_OP: begin
                            o_mem_req <= 1'b1;
                            o_mem_we <= 1'b0;
                            o_mem_io <= 1'b0;
                            o_mem_word <= 1'b1;
                            o_mem_addr <= stk_pop_addr;
                        end
                        `OAC_OP_IN: begin
                            o_mem_req <= 1'b1;
                            o_mem_we <= 1'b0;
                            o_mem_io <= 1'b1;
                            o_mem_word <= word;
                            o_mem_addr <= {4'h0, port};
                        end
                        default: begin
                            if (!ea_is_reg && needs_rm && (op < `OAC_OP_PUSH)) begin
                                o_mem_req <= 1'b1;
                                o_mem_we <= 1'b0;
                                o_mem_io <= 1'b0;
                                o_mem_word <= word;
                                o_mem_addr <= phys;
                            end
                        end
                    endcase
                    if (o_mem_req && i_mem_ack) begin
                        o_mem_req <= 1'b0;
                        opnd_mem <= word || (op == `OAC_OP_POP) || (op == `OAC_OP_FLAGS_POP_OP) ?
                            i_mem_rdata : {8'h00, i_mem_rdata[7:0]};
                        state <= ST_EXEC;
                    end else if (!o_mem_req && !((op == `OAC_OP_POP) || (op == `OAC_OP_FLAGS_POP_OP) ||
                            (op == `OAC_OP_IN) || (!ea_is_reg && needs_rm && (op < `OAC_OP_PUSH)))) begin
                        state <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    result <= raw[15:0];
                    wr_dst <= 1'b0;
                    state <= ST_DONE;
                    if (sets_flags) begin
                        flags[`OAC_F_ZF] <= res_zero;
                        flags[`OAC_F_SF] <= res_sign;
                        flags[`OAC_F_CF] <= logic_op ? 1'b0 : res_cy;
                        flags[`OAC_F_OF] <= 1'b0;
                    end
                    case (op)
                        `OAC_OP_TEST, `OAC_OP_CMP: wr_dst <= 1'b0;
                        `OAC_OP_PUSH, `OAC_OP_FLAGS_PUSH_OP: begin
                            gpr[`OAC_R_SP] <= sp_dec;
                            o_mem_addr <= stk_push_addr;
                            o_mem_wdata <= (op == `OAC_OP_FLAGS_PUSH_OP) ? flags : rd_reg(reg_f, 1'b1);
                            o_mem_word <= 1'b1;
                            o_mem_io <= 1'b0;
                            state <= ST_WRITE;
                        end
                        `OAC_OP_POP: begin
                            gpr[reg_f] <= opnd_mem;
                            gpr[`OAC_R_SP] <= sp + `OAC_WORD_STEP;
                        end
                        `OAC_OP_FLAGS_POP_OP: begin
                            flags <= (opnd_mem & `OAC_FLAGS_MASK) | `OAC_FLAGS_RST;
                            gpr[`OAC_R_SP] <= sp + `OAC_WORD_STEP;
                        end
                        `OAC_OP_IN: begin
                            if (word) begin
                                gpr[`OAC_R_AX] <= opnd_mem;
                            end else begin
                                gpr[`OAC_R_AX][7:0] <= opnd_mem[7:0];
                            end
                        end
                        `OAC_OP_OUT: begin
                            o_mem_addr <= {4'h0, port};
                            o_mem_wdata <= word ? gpr[`OAC_R_AX] : {8'h00, al};
                            o_mem_word <= word;
                            o_mem_io <= 1'b1;
                            state <= ST_WRITE;
                        end
                        `OAC_OP_FL2AH: gpr[`OAC_R_AX][15:8] <= flags[7:0];
                        `OAC_OP_AH2FL: flags[7:0] <= (gpr[`OAC_R_AX][15:8] & 8'hD5) | 8'h02;
                        `OAC_OP_JREL: begin
                            o_next_ip <= i_ip + disp;
                            o_fetch_addr <= {i_cs, 4'h0} + {4'h0, i_ip + disp};
                            o_branch <= 1'b1;
                        end
                        `OAC_OP_DAA, `OAC_OP_AAA: begin
                            gpr[`OAC_R_AX] <= (op == `OAC_OP_DAA) ? {gpr[`OAC_R_AX][15:8], raw[7:0]} : raw[15:0];
                            flags[`OAC_F_AF] <= raw[16];
                            flags[`OAC_F_CF] <= raw[16];
                        end
                        default: begin
                            if (dst_is_mem) begin
                                o_mem_addr <= phys;
                                o_mem_wdata <= word ? raw[15:0] : {8'h00, raw[7:0]};
                                o_mem_word <= word;
                                o_mem_io <= 1'b0;
                                state <= ST_WRITE;
                            end else begin
                                wr_dst <= 1'b1;
                            end
                        end
                    endcase
                end
                ST_WRITE: begin
                    o_mem_req <= 1'b1;
                    o_mem_we <= 1'b1;
                    if (o_mem_req && i_mem_ack) begin
                        o_mem_req <= 1'b0;
                        o_mem_we <= 1'b0;
                        state <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    if (wr_dst) begin
                        if (word) begin
                            gpr[imm_src || to_mem ? rm_f : reg_f] <= result;
                        end else if ((imm_src || to_mem ? rm_f : reg_f) > 3'h3) begin
                            gpr[{1'b0, (imm_src || to_mem ? rm_f[1:0] : reg_f[1:0])}][15:8] <= result[7:0];
                        end else begin
                            gpr[imm_src || to_mem ? rm_f : reg_f][7:0] <= result[7:0];
                        end
                    end
                    wr_dst <= 1'b0;
                    o_done <= 1'b1;
                    state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
    always @* begin
        o_flags = flags;
        o_accumulator_word = gpr[`OAC_R_AX];
        o_stack_pointer_reg = gpr[`OAC_R_SP];
    end
endmodule // oac_decoder
`default_nettype wire

/* File: testbench/oac_mem_model.sv */
// Memory and port space model for the decoder bus
`timescale 1ns/1ps
`default_nettype none
module oac_mem_model #(parameter int LAT = 1) (
    input wire logic clk,
    input wire logic req,
    input wire logic we,
    input wire logic [19:0] addr,
    input wire logic [15:0] wdata,
    output logic ack = 1'b0,
    output logic [15:0] rdata = 16'h0000
);
    // Low address byte only; tests rely on higher addresses aliasing into it
    logic [15:0] mem [256];
    int cnt = 0;
    always @(posedge clk) begin
        ack <= 1'b0;
        // Stale bus toggles, so the old value shows again every other cycle
        rdata <= ~rdata;
        if (req && !ack && cnt < LAT) begin
            cnt <= cnt + 1;
        end else if (req && !ack) begin
            cnt <= 0;
            ack <= 1'b1;
            if (we) begin
                mem[addr[7:0]] <= wdata;
            end else begin
                rdata <= mem[addr[7:0]];
            end
        end
    end
endmodule // oac_mem_model
`default_nettype wire

/* File: testbench/oac_chk_asserts.sv */
// Port checker for the decoder
`timescale 1ns/1ps
`default_nettype none
module oac_chk (
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_start,
    input wire logic [4:0] i_op,
    input wire logic [7:0] i_modrm,
    input wire logic [15:0] i_cs,
    input wire logic i_mem_ack,
    input wire logic o_mem_req,
    input wire logic [19:0] o_mem_addr,
    input wire logic o_busy,
    input wire logic o_done,
    input wire logic o_branch,
    input wire logic [15:0] o_next_ip,
    input wire logic [19:0] o_fetch_addr
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);
    req_hold_a: assert property (o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr)) else $error("req");
    done_pulse_a: assert property (o_done |=> !o_done) else $error("done");
    branch_pulse_a: assert property (o_branch |=> !o_branch) else $error("branch");
    idle_after_a: assert property (o_done |-> !o_busy) else $error("idle");
    start_take_a: assert property (i_start && !o_busy |=> o_busy) else $error("start");
    reg_latency_a: assert property (i_start && !o_busy && i_modrm[7:6] == 2'h3 && i_op < 5'h0B
        |=> !o_mem_req [*4] ##0 o_done) else $error("latency");
    fetch_form_a: assert property (o_branch |-> o_fetch_addr == {i_cs, 4'h0} + {4'h0, o_next_ip})
        else $error("fetch");
    reset_quiet_a: assert property (disable iff (1'b0) i_srst |=> !o_mem_req && !o_done) else $error("rst");
endmodule // oac_chk
bind oac_decoder oac_chk chk (.*);
`default_nettype wire

/* File: testbench/tb.sv */
// Self-checking bench for the decoder
`timescale 1ns/1ps
`default_nettype none
`include "oac_defs.vh"
module tb;
    logic i_ref_clk = 1'b0, i_srst = 1'b1, i_start = 1'b0, i_word = 1'b1, i_imm_src = 1'b0, i_dir_to_mem = 1'b1;
    logic i_seg_ovr_en = 1'b0, i_shift_by_cl = 1'b0, i_mem_ack, o_mem_req, o_mem_we, o_mem_io, o_mem_word;
    logic o_busy, o_done, o_branch;
    logic [1:0] i_seg_ovr = 2'h0;
    logic [4:0] i_op = 5'h00;
    logic [7:0] i_modrm = 8'h00, i_shift_cnt = 8'h04;
    logic [15:0] i_disp = 16'h0000, i_imm = 16'h0000, i_port = 16'h0080, i_ip = 16'h0100, i_cs = 16'h1000;
    logic [15:0] i_ss = 16'h0020, i_ds = 16'h0010, i_es = 16'h0030, i_mem_rdata, o_mem_wdata, o_next_ip, o_flags;
    logic [15:0] o_accumulator_word, o_stack_pointer_reg, wd, bip;
    logic [19:0] o_mem_addr, o_fetch_addr, wa, bfa;
    logic [1:0] wk;
    int n_errors = 0;
    int checks_done = 0;
    always #50 i_ref_clk = ~i_ref_clk;
    oac_decoder DUT (.*);
    oac_mem_model #(.LAT(2)) mem (.clk(i_ref_clk), .req(o_mem_req), .we(o_mem_we), .addr(o_mem_addr),
        .wdata(o_mem_wdata), .ack(i_mem_ack), .rdata(i_mem_rdata));
    always @(posedge i_ref_clk) begin
        if (o_mem_req && o_mem_we && i_mem_ack) begin
            wa <= o_mem_addr;
            wd <= o_mem_wdata;
            wk <= {o_mem_io, o_mem_word};
        end
        if (o_branch) begin
            bip <= o_next_ip;
            bfa <= o_fetch_addr;
        end
    end
    task automatic chk(input string nm, input logic [19:0] s, input logic [19:0] e);
        checks_done++;
        if (s !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic complete_run;
        if (n_errors == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic run(input logic [4:0] op, input logic [7:0] m, input logic s, input logic [15:0] d, im);
        int k;
        i_op <= op;
        i_modrm <= m;
        i_imm_src <= s;
        i_disp <= d;
        i_imm <= im;
        i_start <= 1'b1;
        @(posedge i_ref_clk);
        i_start <= 1'b0;
        for (k = 0; k < 40 && o_done !== 1'b1; k++)
            @(posedge i_ref_clk);
        chk("done", k < 40, 1'b1);
        @(posedge i_ref_clk);
    endtask
    task automatic t_modes;
        logic [7:0] m [5] = '{8'h06, 8'h07, 8'h87, 8'h80, 8'h80};
        logic [15:0] d [5] = '{16'h0040, 16'h0000, 16'h0005, 16'h000C, 16'hFF00};
        logic [19:0] e [5] = '{20'h00140, 20'h00210, 20'h00215, 20'h0023C, 20'h00130};
        run(`OAC_OP_MOVE, 8'hC0, 1'b1, 16'h0000, 16'h1234);
        chk("acc", o_accumulator_word, 16'h1234);
        run(`OAC_OP_MOVE, 8'hC3, 1'b1, 16'h0000, 16'h0110);
        run(`OAC_OP_MOVE, 8'hC6, 1'b1, 16'h0000, 16'h0020);
        for (int i = 0; i < 5; i++) begin
            run(`OAC_OP_MOVE, m[i], 1'b1, d[i], 16'hF0F0);
            chk("ea", wa, e[i]);
        end
    endtask
    task automatic t_memops;
        run(`OAC_OP_AND, 8'h06, 1'b1, 16'h0040, 16'h3C3C);
        chk("rmw", {wd, wa[3:0]}, 20'h30300);
        chk("rmw_a", wa, 20'h00140);
        run(`OAC_OP_TEST, 8'h06, 1'b1, 16'h0040, 16'h0000);
        chk("zf", o_flags[`OAC_F_ZF], 1'b1);
        chk("kept", mem.mem[8'h40], 16'h3030);
        i_dir_to_mem <= 1'b0;
        run(`OAC_OP_MOVE, 8'h06, 1'b0, 16'h0040, 16'h0000);
        chk("load", o_accumulator_word, 16'h3030);
        i_dir_to_mem <= 1'b1;
    endtask
    task automatic t_flow;
        run(`OAC_OP_PUSH, 8'hC0, 1'b0, 16'h0000, 16'h0000);
        chk("sp", o_stack_pointer_reg, 16'hFFFE);
        chk("push", wa, 20'h101FE);
        chk("push_k", wk, 2'h1);
        run(`OAC_OP_OUT, 8'h00, 1'b0, 16'h0000, 16'h0000);
        chk("out", {wd, wa[3:0]}, 20'h30300);
        chk("out_a", wa, 20'h00080);
        chk("out_k", wk, 2'h3);
        run(`OAC_OP_JREL, 8'h00, 1'b0, 16'h0010, 16'h0000);
        chk("ip", {bip, 4'h0}, 20'h01100);
        chk("fetch", bfa, 20'h10110);
    endtask
    task automatic t_ops;
        i_port <= 16'h0010;
        run(`OAC_OP_IN, 8'h00, 1'b0, 16'h0000, 16'h0000);
        chk("in", o_accumulator_word, 16'hF0F0);
        run(`OAC_OP_POP, 8'hC0, 1'b0, 16'h0000, 16'h0000);
        chk("pop", o_accumulator_word, 16'h3030);
        chk("sp_pop", o_stack_pointer_reg, 16'h0000);
        run(`OAC_OP_FL2AH, 8'h00, 1'b0, 16'h0000, 16'h0000);
        chk("fl2ah", o_accumulator_word, 16'h4230);
        run(`OAC_OP_SHL, 8'hC0, 1'b0, 16'h0000, 16'h0000);
        chk("shl", o_accumulator_word, 16'h2300);
        i_word <= 1'b0;
        run(`OAC_OP_ADD, 8'hC0, 1'b1, 16'h0000, 16'h00F0);
        run(`OAC_OP_ADD, 8'hC0, 1'b1, 16'h0000, 16'h0020);
        chk("add8", o_accumulator_word, 16'h2310);
        chk("cf8", o_flags[`OAC_F_CF], 1'b1);
        run(`OAC_OP_DAA, 8'h00, 1'b0, 16'h0000, 16'h0000);
        chk("daa", o_accumulator_word, 16'h2370);
    endtask
    initial begin
        repeat (6) @(posedge i_ref_clk);
        i_srst <= 1'b0;
        @(posedge i_ref_clk);
        t_modes;
        t_memops;
        t_flow;
        t_ops;
        complete_run;
    end
    // Far above the few hundred cycles used
    initial begin
        #300000;
        n_errors++;
        complete_run;
    end
endmodule // tb
`default_nettype wire
